// [core/media_side_clock_frame_timing.sv]
`timescale 1ns/1ps
`include "clk_frame_regs.svh"
// Functional notes
// - Mode 00 uses on-chip recovered and synthesized clocks for both directions.
// - Mode 01 uses the external serial receive and transmit clock pairs.
// - Upper mode bit set selects parallel mode on the parallel clock inputs.
// - Mode 00 with source field 10 feeds the synthesizer from the parallel pin.
// - Media alarm input level is mirrored into a readable status bit.
// - Inclusion bit set adds the media alarm to loss of signal conditions.
// - Three alarm pins each show a selected combination of error conditions.
// - While frame-synchronized, an 8 kHz one-cycle receive frame pulse is emitted.
// - An 8 kHz one-cycle transmit frame pulse is emitted on the system clock.
// - Suspend sampled high halts frames; low restarts at a frame start.
// - Output resumes on the ninth edge after the last high suspend sample.
// - Receive system clock is the selected receive line clock divided by 8.
// - Transmit system clock is the selected transmit clock divided by 8.
// - Both system clock outputs stay stopped while reset is asserted.
// - Serial transmit clock output never carries the recovered receive clock.
// - Parallel receive data is sampled on parallel receive clock rising edges.
module media_side_clock_frame_timing
    import clk_frame_pkg::*;
#(
    parameter int FRAME_LEN = `FRAME_SYS_CYCLES,
    parameter int ALARM_SRCS = `ALARM_SRC_COUNT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] mode_sel,
    input wire logic [1:0] tx_clock_source_field,
    input wire logic recovered_rx_clock,
    input wire logic synth_tx_clock,
    input wire logic rx_serial_clock_pair,
    input wire logic tx_serial_clock_pair,
    input wire logic parallel_rx_clock_in,
    input wire logic parallel_tx_clock_in,
    input wire logic [7:0] parallel_rx_data_in,
    input wire logic frame_sync_in,
    input wire logic tx_frame_suspend,
    input wire logic media_alarm_in,
    input wire logic los_detect_in,
    input wire logic los_media_alarm_include,
    input wire logic [ALARM_SRCS-3:0] alarm_condition_in,
    input wire logic [`ALARM_PIN_COUNT-1:0][ALARM_SRCS-1:0] alarm_pin_map_reg,
    output logic rx_sys_clock,
    output logic tx_sys_clock,
    output logic serial_tx_clock_out,
    output logic synth_source_parallel,
    output logic rx_frame_pulse,
    output logic tx_frame_pulse,
    output logic tx_frame_active,
    output logic media_alarm_status,
    output logic media_alarm_event,
    output logic los_out,
    output logic [`ALARM_PIN_COUNT-1:0] line_alarm_out,
    output logic [7:0] parallel_rx_data,
    output logic parallel_rx_valid
);

    localparam int FW = $clog2(FRAME_LEN);
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_LEN - 1);
    localparam logic [3:0] RESUME_WAIT = 4'(`RESUME_EDGE - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        divider_t rx_div;
        divider_t tx_div;
        logic prx_prev;
        rx_byte_t prx;
        logic [FW-1:0] rx_cnt;
        logic [FW-1:0] tx_cnt;
        logic rx_fp;
        logic tx_fp;
        logic active;
        logic [3:0] resume_cnt;
        logic tx_clk_out;
        logic synth_par;
        logic alm_stat;
        logic alm_evt;
        logic los;
        logic [`ALARM_PIN_COUNT-1:0] pins;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    media_mode_t mode;
    logic rx_src;
    logic tx_src;
    logic rx_sys_rise;
    logic tx_sys_rise;
    logic [ALARM_SRCS-1:0] err_vec;

    // ------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------
    // Mode decode; the pins are treated as static after reset
    always_comb begin
        if (mode_sel[`MODE_SEL_PARALLEL_BIT]) begin
            mode = MODE_PARALLEL;
        end else if (mode_sel == `MODE_SEL_EXTERNAL) begin
            mode = MODE_EXTERNAL;
        end else begin
            mode = MODE_ONCHIP;
        end
    end

    // Line clock multiplexers; recovered clock never reaches the tx path
    always_comb begin
        case (mode)
            MODE_PARALLEL: begin
                rx_src = parallel_rx_clock_in;
                tx_src = parallel_tx_clock_in;
            end
            MODE_EXTERNAL: begin
                rx_src = rx_serial_clock_pair;
                tx_src = tx_serial_clock_pair;
            end
            default: begin
                rx_src = recovered_rx_clock;
                tx_src = synth_tx_clock;
            end
        endcase
    end

    // System clock rising edges: divider phase moving into its upper half
    assign rx_sys_rise = (st_r.rx_div.phase == 3'h3) && rx_src && !st_r.rx_div.src_prev;
    assign tx_sys_rise = (st_r.tx_div.phase == 3'h3) && tx_src && !st_r.tx_div.src_prev;

    // Error vector seen by the alarm pins
    assign err_vec = {alarm_condition_in, st_r.los, st_r.alm_stat};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // divide receive line clock by 8
        st_nxt.rx_div.src_prev = rx_src;
        if (rx_src && !st_r.rx_div.src_prev) begin
            st_nxt.rx_div.phase = st_r.rx_div.phase + 3'h1;
        end
        st_nxt.rx_div.sys_out = st_nxt.rx_div.phase[`SYS_PHASE_MSB];

        st_nxt.tx_div.src_prev = tx_src;
        if (tx_src && !st_r.tx_div.src_prev) begin
            st_nxt.tx_div.phase = st_r.tx_div.phase + 3'h1;
        end
        st_nxt.tx_div.sys_out = st_nxt.tx_div.phase[`SYS_PHASE_MSB];

        // serial tx clock from synthesizer or external pair only
        st_nxt.tx_clk_out = (mode == MODE_PARALLEL) ? 1'b0 : tx_src;

        // synthesizer source from the parallel transmit clock pin
        st_nxt.synth_par = (mode == MODE_ONCHIP)
            && (tx_clock_source_field == `TX_SRC_PARALLEL_PIN);

        // capture parallel receive bytes on the parallel clock
        st_nxt.prx_prev = parallel_rx_clock_in;
        st_nxt.prx.valid = 1'b0;
        if (mode == MODE_PARALLEL && parallel_rx_clock_in && !st_r.prx_prev) begin
            st_nxt.prx.data = parallel_rx_data_in;
            st_nxt.prx.valid = 1'b1;
        end

        // receive frame counter and pulse, one system cycle wide
        if (rx_sys_rise) begin
            st_nxt.rx_fp = 1'b0;
            if (st_r.rx_cnt == FRAME_LAST) begin
                st_nxt.rx_cnt = '0;
                st_nxt.rx_fp = frame_sync_in;
            end else begin
                st_nxt.rx_cnt = st_r.rx_cnt + FW'(1);
            end
        end

        // Transmit frame timing, evaluated on each tx system clock rising edge
        if (tx_sys_rise) begin
            st_nxt.tx_fp = 1'b0;
            if (tx_frame_suspend) begin
                // halt frames while suspend is sampled high
                st_nxt.active = 1'b0;
                st_nxt.resume_cnt = RESUME_WAIT;
                st_nxt.tx_cnt = '0;
            end else if (!st_r.active) begin
                if (st_r.resume_cnt != 4'h0) begin
                    st_nxt.resume_cnt = st_r.resume_cnt - 4'h1;
                end else begin
                    st_nxt.active = 1'b1;
                    st_nxt.tx_fp = 1'b1;
                    // Resume pulse is a frame start, so the first frame keeps its full length
                    st_nxt.tx_cnt = '0;
                end
            end else if (st_r.tx_cnt == FRAME_LAST) begin
                // frame pulse every 2430 system cycles
                st_nxt.tx_cnt = '0;
                st_nxt.tx_fp = 1'b1;
            end else begin
                st_nxt.tx_cnt = st_r.tx_cnt + FW'(1);
            end
        end

        st_nxt.alm_stat = media_alarm_in;
        st_nxt.alm_evt = media_alarm_in ^ st_r.alm_stat;
        // media alarm optionally joins loss of signal
        st_nxt.los = los_detect_in | (los_media_alarm_include & media_alarm_in);

        // each pin ORs its selected error conditions
        for (int i = 0; i < `ALARM_PIN_COUNT; i++) begin
            st_nxt.pins[i] = |(err_vec & alarm_pin_map_reg[i]);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // reset clears dividers so both system clocks stand still
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            // Transmit path counts as active until a suspend is sampled
            st_r.active <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign rx_sys_clock = st_r.rx_div.sys_out;
    assign tx_sys_clock = st_r.tx_div.sys_out;
    assign serial_tx_clock_out = st_r.tx_clk_out;
    assign synth_source_parallel = st_r.synth_par;
    assign rx_frame_pulse = st_r.rx_fp;
    assign tx_frame_pulse = st_r.tx_fp;
    assign tx_frame_active = st_r.active;
    assign media_alarm_status = st_r.alm_stat;
    assign media_alarm_event = st_r.alm_evt;
    assign los_out = st_r.los;
    assign line_alarm_out = st_r.pins;
    assign parallel_rx_data = st_r.prx.data;
    assign parallel_rx_valid = st_r.prx.valid;

endmodule : media_side_clock_frame_timing

// [core/clk_frame_regs.svh]
`ifndef CLK_FRAME_REGS_SVH
`define CLK_FRAME_REGS_SVH

// Media mode select codes
`define MODE_SEL_ONCHIP 2'h0
`define MODE_SEL_EXTERNAL 2'h1
`define MODE_SEL_PARALLEL_BIT 1

// Transmit clock source field code: parallel pin feeds the synthesizer
`define TX_SRC_PARALLEL_PIN 2'h2

// Line clock to system clock divide ratio, and phase bit used as system clock
`define SYS_CLOCK_DIV 8
`define SYS_PHASE_MSB 2

// Frame timing: system clock in kHz over frame rate in kHz
`define SYS_CLOCK_KHZ 19440
`define FRAME_RATE_KHZ 8
`define FRAME_SYS_CYCLES (`SYS_CLOCK_KHZ / `FRAME_RATE_KHZ)

// Resume comes on this system clock edge after the last high suspend sample
`define RESUME_EDGE 9

// Alarm sources: bit 0 media alarm, bit 1 loss of signal, rest external
`define ALARM_BIT_MEDIA 0
`define ALARM_BIT_LOS 1
`define ALARM_SRC_COUNT 12
`define ALARM_PIN_COUNT 3

`endif

// [core/clk_frame_pkg.sv]
package clk_frame_pkg;

    typedef enum logic [1:0] {
        MODE_ONCHIP,
        MODE_EXTERNAL,
        MODE_PARALLEL
    } media_mode_t;

    // One divider: phase counter and previous level of the source clock
    typedef struct packed {
        logic [2:0] phase;
        logic src_prev;
        logic sys_out;
    } divider_t;

    // Receive byte capture in parallel mode
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } rx_byte_t;

endpackage : clk_frame_pkg

// [tb/clk_frame_monitor.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module clk_frame_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] mode_sel,
    input wire logic [1:0] tx_clock_source_field,
    input wire logic tx_sys_clock,
    input wire logic rx_sys_clock,
    input wire logic serial_tx_clock_out,
    input wire logic synth_source_parallel,
    input wire logic tx_frame_pulse,
    input wire logic rx_frame_pulse,
    input wire logic tx_frame_active,
    input wire logic frame_sync_in,
    input wire logic media_alarm_in,
    input wire logic media_alarm_status,
    input wire logic media_alarm_event,
    input wire logic los_detect_in,
    input wire logic los_media_alarm_include,
    input wire logic los_out,
    input wire logic [7:0] parallel_rx_data_in,
    input wire logic [7:0] parallel_rx_data,
    input wire logic parallel_rx_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_SYS_STOP: assert property (disable iff (1'b0) !rst_n |-> !tx_sys_clock && !rx_sys_clock)
        else $error("system clock runs in reset");
    AST_SYNTH_SRC: assert property ($past(rst_n) |-> synth_source_parallel ==
        ($past(mode_sel) == 2'h0 && $past(tx_clock_source_field) == 2'h2))
        else $error("synth source flag wrong");
    AST_PAR_TXOUT: assert property (mode_sel[1] |-> !serial_tx_clock_out)
        else $error("serial clock out in parallel mode");
    // half period at least 4 rises
    AST_TX_DIV: assert property ($rose(tx_sys_clock) |-> tx_sys_clock [*8])
        else $error("tx system clock high too short");
    AST_TX_PULSE: assert property ($rose(tx_frame_pulse) |-> $rose(tx_sys_clock))
        else $error("tx frame pulse off system edge");
    AST_RX_SYNC: assert property ($rose(rx_frame_pulse) |-> $past(frame_sync_in))
        else $error("rx frame pulse without sync");
    AST_HALT: assert property ($rose(tx_frame_pulse) |-> tx_frame_active)
        else $error("tx frame pulse while halted");
    AST_ALARM: assert property ($past(rst_n) |-> media_alarm_status == $past(media_alarm_in) &&
        los_out == $past(los_detect_in | (los_media_alarm_include & media_alarm_in)))
        else $error("alarm status or los wrong");
    AST_EVENT: assert property ($past(rst_n, 3) |-> media_alarm_event ==
        (media_alarm_status != $past(media_alarm_status)))
        else $error("alarm event wrong");
    AST_PAR_RX: assert property (parallel_rx_valid |->
        mode_sel[1] && parallel_rx_data == $past(parallel_rx_data_in) ##1 !parallel_rx_valid)
        else $error("parallel capture wrong");
endmodule : clk_frame_monitor

bind media_side_clock_frame_timing clk_frame_monitor clk_frame_monitor_i (.clk, .rst_n,
    .mode_sel, .tx_clock_source_field, .tx_sys_clock, .rx_sys_clock, .serial_tx_clock_out,
    .synth_source_parallel, .tx_frame_pulse, .rx_frame_pulse, .tx_frame_active, .frame_sync_in,
    .media_alarm_in, .media_alarm_status, .media_alarm_event, .los_detect_in,
    .los_media_alarm_include, .los_out, .parallel_rx_data_in, .parallel_rx_data,
    .parallel_rx_valid);

// [tb/line_xcvr_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Line transceiver model
// ----------------------------------------
module line_xcvr_model (
    input wire logic clk,
    output logic [2:0] line_clk,
    output logic [7:0] rx_byte
);
    logic [3:0] cnt_r = '0;
    // Free running; each source a distinct rate so selection shows in width
    always_ff @(posedge clk) begin
        cnt_r <= (cnt_r == 4'hb) ? 4'h0 : cnt_r + 4'h1;
    end
    // clocks always supplied, line 2 feeds parallel pins
    always_comb begin
        line_clk[0] = cnt_r[0];
        line_clk[1] = cnt_r[1];
        line_clk[2] = (cnt_r >= 4'h3 && cnt_r < 4'h6) || cnt_r >= 4'h9;
        rx_byte = {cnt_r, ~cnt_r};
    end
endmodule : line_xcvr_model

// [tb/testbench.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Top bench
// ----------------------------------------
module testbench;
    // Reset starts released so that its first assertion is a real edge
    logic clk = 0, rst_n = 1, frame_sync_in = 0, tx_frame_suspend = 0;
    logic media_alarm_in = 0, los_detect_in = 0, los_media_alarm_include = 0;
    logic [1:0] mode_sel = 0, tx_clock_source_field = 2'h2;
    logic [9:0] alarm_condition_in = 10'h001;
    logic [2:0][11:0] alarm_pin_map_reg = {12'h004, 12'h002, 12'h001};
    logic rx_sys_clock, tx_sys_clock, serial_tx_clock_out, synth_source_parallel;
    logic rx_frame_pulse, tx_frame_pulse, tx_frame_active, media_alarm_status;
    logic media_alarm_event, los_out, parallel_rx_valid;
    logic [2:0] line_alarm_out, line_clk;
    logic [7:0] parallel_rx_data, rx_byte;
    int num_errors = 0, tests_run = 0;

    always #50 clk = ~clk;

    line_xcvr_model line_xcvr_model_i (.clk, .line_clk, .rx_byte);
    // Short frames keep the run brief
    media_side_clock_frame_timing #(.FRAME_LEN(8)) media_side_clock_frame_timing_i (.clk,
        .rst_n, .mode_sel, .tx_clock_source_field, .recovered_rx_clock(line_clk[0]),
        .synth_tx_clock(line_clk[0]), .rx_serial_clock_pair(line_clk[1]),
        .tx_serial_clock_pair(line_clk[1]), .parallel_rx_clock_in(line_clk[2]),
        .parallel_tx_clock_in(line_clk[2]), .parallel_rx_data_in(rx_byte), .frame_sync_in,
        .tx_frame_suspend, .media_alarm_in, .los_detect_in, .los_media_alarm_include,
        .alarm_condition_in, .alarm_pin_map_reg, .rx_sys_clock, .tx_sys_clock,
        .serial_tx_clock_out, .synth_source_parallel, .rx_frame_pulse, .tx_frame_pulse,
        .tx_frame_active, .media_alarm_status, .media_alarm_event, .los_out, .line_alarm_out,
        .parallel_rx_data, .parallel_rx_valid);

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    function automatic logic probe(input int s);
        return s == 0 ? tx_sys_clock : s == 1 ? rx_sys_clock : s == 2 ? serial_tx_clock_out :
            s == 3 ? tx_frame_pulse : rx_frame_pulse;
    endfunction : probe

    // High width of a signal; bounded so a dead output reads as a short width
    task automatic meas(input int s, output logic [15:0] w);
        int k;
        k = 0;
        w = 0;
        while (k < 300 && probe(s)) begin tick(1); k++; end
        while (k < 600 && !probe(s)) begin tick(1); k++; end
        while (k < 900 && probe(s)) begin tick(1); k++; w++; end
    endtask : meas

    task automatic start(input logic [1:0] m);
        rst_n = 0;
        mode_sel = m;
        tick(4);
        check(tx_sys_clock, 0);
        check({rx_sys_clock, tx_frame_active}, 1);
        rst_n = 1;
    endtask : start

    task automatic wrap_up();
        $display("errors %0d in %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        logic [15:0] w;
        int h;
        #10;
        for (int m = 0; m < 4; m++) begin
            h = m > 1 ? 3 : m + 1;
            start(m[1:0]);
            tick(2);
            check(synth_source_parallel, m == 0);
            meas(0, w);
            check(w, 8 * h);
            meas(1, w);
            check(w, 8 * h);
            meas(2, w);
            check(w, m < 2 ? h : 0);
        end
        w = 0;
        repeat (20) begin tick(1); w += parallel_rx_valid; end
        check(w > 0, 1);
        start(0);
        meas(4, w);
        check(w, 0);
        frame_sync_in = 1;
        meas(3, w);
        check(w, 16);
        meas(4, w);
        check(w, 16);
        tx_frame_suspend = 1;
        tick(40);
        check(tx_frame_active, 0);
        while (tx_sys_clock) tick(1);
        while (!tx_sys_clock) tick(1);
        tx_frame_suspend = 0;
        h = 0;
        while (h < 300 && !tx_frame_pulse) begin tick(1); h++; end
        check(h, 144);
        check(tx_frame_active, 1);
        // First frame after resume must be a full frame
        h = 0;
        while (h < 300 && (h < 16 || !tx_frame_pulse)) begin tick(1); h++; end
        check(h, 128);
        media_alarm_in = 1;
        tick(1);
        check(media_alarm_event, 1);
        tick(1);
        check(media_alarm_event, 0);
        check(media_alarm_status, 1);
        check(line_alarm_out, 3'h5);
        check(los_out, 0);
        los_media_alarm_include = 1;
        alarm_condition_in = 10'h000;
        tick(3);
        check(los_out, 1);
        check(line_alarm_out, 3'h3);
        media_alarm_in = 0;
        los_media_alarm_include = 0;
        los_detect_in = 1;
        tick(1);
        check(media_alarm_event, 1);
        check(los_out, 1);
        wrap_up();
    end

    // Whole run is a few thousand cycles; this is over fifteen times that
    initial begin
        #5000000;
        num_errors++;
        wrap_up();
    end
endmodule : testbench
